// [src/vcfg_pkg.sv]
package vcfg_pkg;

    // Register bus shape
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_VFCTL = 16'hc000;
    localparam logic [ADDR_W-1:0] OFF_MIRROR_LO = 16'hc100;
    localparam logic [ADDR_W-1:0] OFF_MIRROR_HI = 16'hc104;
    localparam logic [ADDR_W-1:0] OFF_INVALIDATE = 16'hc120;

    // Virtual function control fields
    localparam int CRED_EN_BIT = 0;
    localparam int SGI_LIM_BIT = 1;
    localparam int LPI_LIM_BIT = 2;
    localparam int CRED_CNT_LSB = 3;
    localparam int CRED_CNT_W = 2;
    localparam int VFCTL_W = 5;
    localparam logic [VFCTL_W-1:0] VFCTL_RESET = 5'h00;

    // Invalidate register fields
    localparam int INV_START_BIT = 31;
    localparam int MASK_MAX_W = 31;

    // Mirror layout: the base address field covers bits 51:12
    localparam int BASE_ADDR_W = 40;
    localparam int CREDIT_W = 3;

    // Request from the register bus master
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
        logic secure;
    } bus_req_type;

    // Fields of the virtual property base register
    typedef struct packed {
        logic [2:0] entry_size;
        logic [2:0] outer_cacheability;
        logic indirect;
        logic [1:0] page_size;
        logic [1:0] shareability;
        logic [2:0] inner_cacheability;
        logic [6:0] size;
    } prop_base_type;

    // Configuration table capture and wake state
    typedef struct packed {
        logic valid;
        logic sleep;
        logic [BASE_ADDR_W-1:0] base_addr;
    } cfg_table_type;

    // Invalidation walker
    typedef enum logic [0:0] {
        WALK_IDLE = 1'b0,
        WALK_RUN = 1'b1
    } walk_state_type;

endpackage

// [src/virtual_intr_config_regs.sv]
// The placing of the registers and strobed register access were left to the implementer.
module virtual_intr_config_regs #(
    parameter int CHIP_COUNT = 4,
    parameter int CC_TOKENS = 4,
    parameter int ENTRIES = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [vcfg_pkg::ADDR_W-1:0] i_addr,
    input wire logic [vcfg_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_secure,
    input wire vcfg_pkg::prop_base_type i_prop_base,
    input wire vcfg_pkg::cfg_table_type i_cfg_table,
    input wire logic i_alloc,
    input wire logic [$clog2(ENTRIES)-1:0] i_alloc_idx,
    input wire logic [(CHIP_COUNT > 1 ? $clog2(CHIP_COUNT) : 1)-1:0] i_alloc_chip,
    input wire logic [$clog2(ENTRIES)-1:0] i_lookup_idx,
    output logic [vcfg_pkg::DATA_W-1:0] o_rdata,
    output logic [vcfg_pkg::CREDIT_W-1:0] o_vsgi_credit,
    output logic o_virtual_lpi_buffer_limit,
    output logic o_virtual_sgi_buffer_limit,
    output logic o_invalidate_busy,
    output logic o_lookup_valid
);
    localparam logic [vcfg_pkg::CREDIT_W-1:0] TOKENS =
        vcfg_pkg::CREDIT_W'(CC_TOKENS);
    localparam logic [vcfg_pkg::CREDIT_W-1:0] TOKEN_MAX_IDX =
        vcfg_pkg::CREDIT_W'(CC_TOKENS - 1);

    // Parameters the datapath cannot carry are refused
    initial begin
        if (CHIP_COUNT < 1 || CHIP_COUNT > vcfg_pkg::MASK_MAX_W) begin
            $error("chip count must lie between 1 and 31");
        end
        if (CC_TOKENS < 1 || CC_TOKENS > 7) begin
            $error("cross chip token count must lie between 1 and 7");
        end
    end

    vcfg_pkg::bus_req_type req;
    logic [vcfg_pkg::VFCTL_W-1:0] vfctl_q;
    logic [vcfg_pkg::CRED_CNT_W-1:0] cred_cnt;
    logic cred_en;
    logic sleep;
    logic [63:0] mirror;
    logic [vcfg_pkg::DATA_W-1:0] rdata_d;
    logic vfctl_hit;
    logic inv_hit;
    logic inv_start;
    logic walk_busy;

    // Bundle the bus request
    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd, secure: i_secure};

    // Effective per-chip credit from the control field
    function automatic logic [vcfg_pkg::CREDIT_W-1:0] eff_credit(
        input logic en,
        input logic [vcfg_pkg::CRED_CNT_W-1:0] cnt
    );
        logic [vcfg_pkg::CREDIT_W-1:0] wide;
        wide = {1'b0, cnt};
        if (en && wide <= TOKEN_MAX_IDX) begin
            eff_credit = wide + 3'h1;
        end else begin
            eff_credit = TOKENS;
        end
    endfunction

    // Mirror word, fixed positions from the property base and table capture
    function automatic logic [63:0] build_mirror(
        input vcfg_pkg::prop_base_type pb,
        input vcfg_pkg::cfg_table_type ct
    );
        build_mirror = {ct.valid, ct.sleep, pb.entry_size, pb.outer_cacheability,
            pb.indirect, pb.page_size, 1'b0, ct.base_addr, pb.shareability,
            pb.inner_cacheability, pb.size};
    endfunction

    assign cred_en = vfctl_q[vcfg_pkg::CRED_EN_BIT];
    assign cred_cnt = vfctl_q[vcfg_pkg::CRED_CNT_LSB +: vcfg_pkg::CRED_CNT_W];
    assign sleep = i_cfg_table.sleep;
    assign mirror = build_mirror(i_prop_base, i_cfg_table);
    assign vfctl_hit = req.addr == vcfg_pkg::OFF_VFCTL;
    assign inv_hit = req.addr == vcfg_pkg::OFF_INVALIDATE;

    // A start while busy is ignored, so no start can meet a finish
    assign inv_start = req.wr && inv_hit && req.wdata[vcfg_pkg::INV_START_BIT] &&
        !walk_busy;

    // Control register, secure writes only
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            vfctl_q <= vcfg_pkg::VFCTL_RESET;
        end else if (req.wr && vfctl_hit && req.secure) begin
            vfctl_q <= req.wdata[vcfg_pkg::VFCTL_W-1:0];
        end
    end

    // Read mux; unmapped offsets and the mask read as zero
    always_comb begin
        rdata_d = '0;
        if (vfctl_hit) begin
            if (req.secure) begin
                rdata_d = {{(vcfg_pkg::DATA_W - vcfg_pkg::VFCTL_W){1'b0}}, vfctl_q};
            end
        end else if (req.addr == vcfg_pkg::OFF_MIRROR_LO) begin
            rdata_d = mirror[31:0];
        end else if (req.addr == vcfg_pkg::OFF_MIRROR_HI) begin
            rdata_d = mirror[63:32];
        end else if (inv_hit) begin
            rdata_d[vcfg_pkg::INV_START_BIT] = walk_busy;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else if (req.rd) begin
            o_rdata <= rdata_d;
        end else begin
            o_rdata <= '0;
        end
    end

    // Limit outputs registered so consumers see a clean level
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_vsgi_credit <= TOKENS;
            o_virtual_lpi_buffer_limit <= 1'b0;
            o_virtual_sgi_buffer_limit <= 1'b0;
        end else begin
            o_vsgi_credit <= eff_credit(cred_en, cred_cnt);
            o_virtual_lpi_buffer_limit <= vfctl_q[vcfg_pkg::LPI_LIM_BIT];
            o_virtual_sgi_buffer_limit <= vfctl_q[vcfg_pkg::SGI_LIM_BIT];
        end
    end

    // Walker owns the RAM; the mask is CHIP_COUNT wide, upper bits dropped
    vpe_chip_ram #(
        .ENTRIES(ENTRIES),
        .CHIP_COUNT(CHIP_COUNT)
    ) walker (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_alloc(i_alloc),
        .i_alloc_idx(i_alloc_idx),
        .i_alloc_chip(i_alloc_chip),
        .i_start(inv_start),
        .i_mask(req.wdata[CHIP_COUNT-1:0]),
        .i_lookup_idx(i_lookup_idx),
        .o_busy(walk_busy),
        .o_lookup_valid(o_lookup_valid)
    );

    // Busy copy for the pin; the register read uses the walker's own flop
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_invalidate_busy <= 1'b0;
        end else begin
            o_invalidate_busy <= walk_busy;
        end
    end

    credit_cap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cred_en && {1'b0, cred_cnt} <= TOKEN_MAX_IDX)
        |=> o_vsgi_credit == {1'b0, $past(cred_cnt)} + 3'h1)
        else $error("credit cap does not follow the count field");

    credit_fallback_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cred_en && {1'b0, cred_cnt} > TOKEN_MAX_IDX) |=> o_vsgi_credit == TOKENS)
        else $error("oversized count did not fall back to token count");

    credit_default_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !cred_en |=> o_vsgi_credit == TOKENS)
        else $error("disabled credit limit did not use token count");

    lpi_limit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (req.wr && vfctl_hit && req.secure) |=> ##1
        o_virtual_lpi_buffer_limit == $past(req.wdata[vcfg_pkg::LPI_LIM_BIT], 2))
        else $error("virtual LPI limit did not follow the write");

    sgi_limit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (req.wr && vfctl_hit && req.secure) |=> ##1
        o_virtual_sgi_buffer_limit == $past(req.wdata[vcfg_pkg::SGI_LIM_BIT], 2))
        else $error("virtual SGI limit did not follow the write");

    nonsecure_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (req.wr && vfctl_hit && !req.secure) |=> $stable(vfctl_q))
        else $error("non-secure write changed the control register");

    nonsecure_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (req.rd && vfctl_hit && !req.secure) |=> o_rdata == '0)
        else $error("non-secure read returned control contents");

    mirror_sleep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (req.rd && req.addr == vcfg_pkg::OFF_MIRROR_HI) |=> o_rdata[30] == $past(sleep))
        else $error("sleep mirror bit wrong");

    mirror_valid_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (req.rd && req.addr == vcfg_pkg::OFF_MIRROR_HI)
        |=> o_rdata[31] == $past(i_cfg_table.valid))
        else $error("valid mirror bit wrong");

    mirror_addr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (req.rd && req.addr == vcfg_pkg::OFF_MIRROR_LO)
        |=> o_rdata[31:12] == $past(i_cfg_table.base_addr[19:0]))
        else $error("base address mirror wrong");

    mask_reads_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (req.rd && inv_hit) |=> o_rdata[30:0] == '0)
        else $error("chip mask field read back nonzero");

    start_sets_busy_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        inv_start |=> walk_busy ##1 o_invalidate_busy)
        else $error("invalidate start did not raise busy");

    busy_clears_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (req.rd && inv_hit && !walk_busy) |=> !o_rdata[vcfg_pkg::INV_START_BIT])
        else $error("finished invalidation still reads as running");

    inv_walk_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        inv_start ##1 walk_busy [*3]);

    fallback_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        cred_en && {1'b0, cred_cnt} > TOKEN_MAX_IDX);

    nonsecure_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        req.wr && vfctl_hit && !req.secure);

endmodule

// [src/vpe_chip_ram.sv]
module vpe_chip_ram #(
    parameter int ENTRIES = 16,
    parameter int CHIP_COUNT = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_alloc,
    input wire logic [$clog2(ENTRIES)-1:0] i_alloc_idx,
    input wire logic [(CHIP_COUNT > 1 ? $clog2(CHIP_COUNT) : 1)-1:0] i_alloc_chip,
    input wire logic i_start,
    input wire logic [CHIP_COUNT-1:0] i_mask,
    input wire logic [$clog2(ENTRIES)-1:0] i_lookup_idx,
    output logic o_busy,
    output logic o_lookup_valid
);
    localparam int IDX_W = $clog2(ENTRIES);
    localparam int CHIP_W = CHIP_COUNT > 1 ? $clog2(CHIP_COUNT) : 1;
    localparam int WALK_BOUND = ENTRIES + 2;
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(ENTRIES - 1);

    initial begin
        if (ENTRIES < 2 || (1 << IDX_W) != ENTRIES) begin
            $error("entry count must be a power of two of at least 2");
        end
    end

    vcfg_pkg::walk_state_type state_q;
    logic [IDX_W-1:0] idx_q;
    logic [IDX_W-1:0] prev_idx_q;
    logic [CHIP_COUNT-1:0] mask_q;
    logic [ENTRIES-1:0] valid_q;
    logic [CHIP_W-1:0] chip_q [ENTRIES];
    logic hit;

    // Entry under the walker is dropped only when its chip is selected
    assign hit = valid_q[idx_q] && mask_q[chip_q[idx_q]];

    // Walk state: one entry per cycle, mask latched at start
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_q <= vcfg_pkg::WALK_IDLE;
            idx_q <= '0;
            mask_q <= '0;
        end else begin
            unique case (state_q)
                vcfg_pkg::WALK_IDLE: begin
                    if (i_start) begin
                        state_q <= vcfg_pkg::WALK_RUN;
                        idx_q <= '0;
                        mask_q <= i_mask;
                    end
                end
                vcfg_pkg::WALK_RUN: begin
                    idx_q <= idx_q + 1'b1;
                    if (idx_q == LAST_IDX) begin
                        state_q <= vcfg_pkg::WALK_IDLE;
                    end
                end
            endcase
        end
    end

    // Valid bits; a fresh allocation beats a clear on the same entry
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            valid_q <= '0;
        end else begin
            if (state_q == vcfg_pkg::WALK_RUN && hit) begin
                valid_q[idx_q] <= 1'b0;
            end
            if (i_alloc) begin
                valid_q[i_alloc_idx] <= 1'b1;
            end
        end
    end

    // Chip tags need no reset, valid bits guard them
    always_ff @(posedge i_clk) begin
        if (i_alloc) begin
            chip_q[i_alloc_idx] <= i_alloc_chip;
        end
    end

    // Registered outputs
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_busy <= 1'b0;
            o_lookup_valid <= 1'b0;
            prev_idx_q <= '0;
        end else begin
            o_busy <= (state_q == vcfg_pkg::WALK_RUN && idx_q != LAST_IDX) ||
                (state_q == vcfg_pkg::WALK_IDLE && i_start);
            o_lookup_valid <= valid_q[i_lookup_idx];
            prev_idx_q <= idx_q;
        end
    end

    walk_ends_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_busy) |-> ##[1:WALK_BOUND] !o_busy)
        else $error("invalidation walk did not finish in time");

    keep_unselected_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == vcfg_pkg::WALK_RUN && valid_q[idx_q] && !hit)
        |=> valid_q[prev_idx_q])
        else $error("entry of an unselected chip was dropped");

    drop_selected_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == vcfg_pkg::WALK_RUN && hit && !(i_alloc && i_alloc_idx == idx_q))
        |=> !valid_q[prev_idx_q])
        else $error("entry of a selected chip survived the walk");

    walk_done_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        $fell(o_busy));

endmodule

// [testbench/virtual_intr_config_regs_tb_top.sv]
module virtual_intr_config_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // Small store and a token count of 3 so the count field overflows it
    localparam int CC = 3;
    localparam int NE = 4;
    localparam int NC = 4;

    logic i_clk;
    logic i_rst_n;
    logic [vcfg_pkg::ADDR_W-1:0] i_addr;
    logic [vcfg_pkg::DATA_W-1:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic i_secure;
    vcfg_pkg::prop_base_type i_prop_base;
    vcfg_pkg::cfg_table_type i_cfg_table;
    logic i_alloc;
    logic [1:0] i_alloc_idx;
    logic [1:0] i_alloc_chip;
    logic [1:0] i_lookup_idx;
    logic [31:0] o_rdata;
    logic [2:0] o_vsgi_credit;
    logic o_virtual_lpi_buffer_limit;
    logic o_virtual_sgi_buffer_limit;
    logic o_invalidate_busy;
    logic o_lookup_valid;
    int err_count = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'hc8013716;

    virtual_intr_config_regs #(.CHIP_COUNT(NC), .CC_TOKENS(CC), .ENTRIES(NE)) dut_u (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .i_secure(i_secure), .i_prop_base(i_prop_base),
        .i_cfg_table(i_cfg_table), .i_alloc(i_alloc), .i_alloc_idx(i_alloc_idx),
        .i_alloc_chip(i_alloc_chip), .i_lookup_idx(i_lookup_idx), .o_rdata(o_rdata),
        .o_vsgi_credit(o_vsgi_credit),
        .o_virtual_lpi_buffer_limit(o_virtual_lpi_buffer_limit),
        .o_virtual_sgi_buffer_limit(o_virtual_sgi_buffer_limit),
        .o_invalidate_busy(o_invalidate_busy), .o_lookup_valid(o_lookup_valid));

    // Free-running 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Plain xorshift keeps the run repeatable
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Reference credit: count field only wins while it fits the tokens
    function automatic int cred(input int v);
        int cnt;
        cnt = (v >> 3) & 3;
        if ((v & 1) != 0 && cnt <= CC - 1) begin
            return cnt + 1;
        end
        return CC;
    endfunction

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected read data at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected output level at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe, address and data held with it
    task automatic bus_wr(input logic [15:0] a, input logic [31:0] d, input logic s);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        i_secure <= s;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [15:0] a, input logic s, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        i_secure <= s;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        logic [31:0] d;
        logic [31:0] hi;
        logic [31:0] lo;
        logic [3:0] mask;
        int vld[NE];
        int n;
        i_rst_n = 1'b0;
        i_addr = '0;
        i_wdata = '0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_secure = 1'b0;
        i_prop_base = '0;
        i_cfg_table = '0;
        i_alloc = 1'b0;
        i_alloc_idx = '0;
        i_alloc_chip = '0;
        i_lookup_idx = '0;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        bus_rd(vcfg_pkg::OFF_VFCTL, 1'b1, d);
        chk_rd(d, 32'h0000_0000);
        chk_out({3'h0, o_vsgi_credit, o_virtual_lpi_buffer_limit, o_virtual_sgi_buffer_limit},
                {3'h0, 3'(CC), 2'b00});
        // Every control value, junk in the reserved bits, non-secure poke in between
        for (int v = 0; v < 32; v++) begin
            bus_wr(vcfg_pkg::OFF_VFCTL, {rnd() & 32'hffff_ffe0} | 32'(v), 1'b1);
            bus_wr(vcfg_pkg::OFF_VFCTL, 32'(~v), 1'b0);
            bus_rd(vcfg_pkg::OFF_VFCTL, 1'b0, d);
            chk_rd(d, 32'h0000_0000);
            bus_rd(vcfg_pkg::OFF_VFCTL, 1'b1, d);
            chk_rd(d, 32'(v));
            chk_out({3'h0, o_vsgi_credit, o_virtual_lpi_buffer_limit,
                     o_virtual_sgi_buffer_limit},
                    {3'h0, 3'(cred(v)), v[2], v[1]});
        end
        // Unmapped places read zero and leave control alone
        bus_wr(16'hc004, 32'hffff_ffff, 1'b1);
        bus_rd(16'hc004, 1'b1, d);
        chk_rd(d, 32'h0000_0000);
        bus_rd(vcfg_pkg::OFF_VFCTL, 1'b1, d);
        chk_rd(d, 32'h0000_001f);
        // Mirror follows live property and table inputs
        for (int k = 0; k < 6; k++) begin
            @(posedge i_clk);
            i_prop_base <= 27'(rnd());
            // Function results cannot be sliced directly, so draw into temporaries
            d = rnd();
            lo = rnd();
            hi = rnd();
            i_cfg_table <= {d[1:0], lo, hi[7:0]};
            @(posedge i_clk);
            hi = {i_cfg_table.valid, i_cfg_table.sleep, i_prop_base.entry_size,
                  i_prop_base.outer_cacheability, i_prop_base.indirect,
                  i_prop_base.page_size, 1'b0, i_cfg_table.base_addr[39:20]};
            lo = {i_cfg_table.base_addr[19:0], i_prop_base.shareability,
                  i_prop_base.inner_cacheability, i_prop_base.size};
            bus_rd(vcfg_pkg::OFF_MIRROR_HI, 1'b0, d);
            chk_rd(d, hi);
            bus_rd(vcfg_pkg::OFF_MIRROR_LO, 1'b0, d);
            chk_rd(d, lo);
        end
        // Invalidation rounds: fill the store, drop a random chip selection, an empty one in round 0
        for (int r = 0; r < 4; r++) begin
            for (int e = 0; e < NE; e++) begin
                @(posedge i_clk);
                i_alloc <= 1'b1;
                i_alloc_idx <= 2'(e);
                i_alloc_chip <= 2'(e + r);
                vld[e] = 1;
            end
            @(posedge i_clk);
            i_alloc <= 1'b0;
            d = rnd();
            mask = (r == 0) ? 4'h0 : d[3:0];
            bus_wr(vcfg_pkg::OFF_INVALIDATE, {1'b1, d[30:4], mask}, 1'b0);
            bus_rd(vcfg_pkg::OFF_INVALIDATE, 1'b0, d);
            chk_rd(d, 32'h8000_0000);
            n = 0;
            while (d[31] !== 1'b0 && n < 3 * NE) begin
                bus_rd(vcfg_pkg::OFF_INVALIDATE, 1'b0, d);
                n++;
            end
            chk_rd(d, 32'h0000_0000);
            @(posedge i_clk);
            #1 chk_out({7'h0, o_invalidate_busy}, 8'h00);
            // Model: only entries whose chip bit is selected disappear
            for (int e = 0; e < NE; e++) begin
                if (mask[(e + r) % NC]) begin
                    vld[e] = 0;
                end
                @(posedge i_clk);
                i_lookup_idx <= 2'(e);
                @(posedge i_clk);
                #1 chk_out({7'h0, o_lookup_valid}, 8'(vld[e]));
            end
        end
        report_and_stop();
    end
endmodule
